// ==== design/bra_pkg.sv ====
// package: constants, register map and carrier types of the bit-reverse address generator
package bra_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] BRA_OFS_MODE_CTRL = 8'h00;
  localparam logic [7:0] BRA_OFS_BITREV_CTRL = 8'h04;
  localparam logic [7:0] BRA_OFS_TABLE_PAGE = 8'h08;
  localparam logic [7:0] BRA_OFS_STATUS = 8'h0C;
  // values after reset
  localparam logic [15:0] BRA_MODE_CTRL_RST = 16'h0FFF;
  localparam logic [15:0] BRA_BITREV_CTRL_RST = 16'h0000;
  localparam logic [7:0] BRA_TABLE_PAGE_RST = 8'h00;
  // field positions
  localparam int BRA_BITREV_EN_BIT = 15;
  localparam int BRA_PIVOT_MSB = 14;
  localparam int BRA_PTR_SEL_LSB = 8;
  localparam int BRA_XMOD_EN_BIT = 15;
  localparam int BRA_XWM_LSB = 0;
  localparam int BRA_CFG_SPACE_BIT = 7;
  localparam logic [3:0] BRA_PTR_NONE = 4'hF;
  // pointer steps for ordinary increments
  localparam logic [15:0] BRA_STEP_WORD = 16'h0002;
  localparam logic [15:0] BRA_STEP_BYTE = 16'h0001;

  // addressing modes driven by the pipeline
  typedef enum logic [2:0] {
    BRA_AM_DIRECT, BRA_AM_INDIRECT, BRA_AM_POST_INC, BRA_AM_POST_DEC,
    BRA_AM_PRE_INC, BRA_AM_PRE_DEC, BRA_AM_REG_OFS, BRA_AM_LIT_OFS
  } bra_mode_t;

  // address request from the execution pipeline
  typedef struct packed {
    logic valid;
    logic [3:0] wreg;
    logic [15:0] wvalue;
    bra_mode_t mode;
    logic [15:0] offset;
    logic byte_access;
    logic write;
    logic table_access;
    logic remap_access;
  } bra_req_t;

  // address answer to the execution pipeline
  typedef struct packed {
    logic valid;
    logic [15:0] ea;
    logic wb_en;
    logic [15:0] wb_value;
    logic bitrev_used;
    logic modulo_apply;
    logic [23:0] ps_addr;
    logic byte_select;
    logic config_space;
    logic low_word_only;
    logic refused;
  } bra_rsp_t;
endpackage : bra_pkg

// ==== design/bra_agu.sv ====
// bit-reversed and program space address generator with apb register slave
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module bra_agu #(
  parameter int PIVOT_W = 15
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // execution pipeline
  input wire bra_pkg::bra_req_t req_i,
  output bra_pkg::bra_rsp_t rsp_o
);
  import bra_pkg::*;

  // register state
  logic [15:0] mode_ctrl;
  logic [15:0] bitrev_control;
  logic [7:0] table_page;
  logic [15:0] last_ea;
  logic [7:0] bitrev_count;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] next_mode_ctrl;
  logic [15:0] next_bitrev_control;
  logic [7:0] next_table_page;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [15:0] next_last_ea;
  logic [7:0] next_bitrev_count;
  bra_rsp_t rsp;
  bra_rsp_t next_rsp;

  // decoded control fields
  logic [3:0] bitrev_pointer_select;
  logic bitrev_enable;
  logic [PIVOT_W-1:0] bitrev_pivot;
  logic [3:0] xmod_sel;
  logic xmod_en;
  logic apb_access;
  logic apb_done;
  logic addr_hit;

  assign bitrev_pointer_select = mode_ctrl[BRA_PTR_SEL_LSB +: 4];
  assign bitrev_enable = bitrev_control[BRA_BITREV_EN_BIT];
  assign bitrev_pivot = bitrev_control[BRA_PIVOT_MSB:0];
  assign xmod_sel = mode_ctrl[BRA_XWM_LSB +: 4];
  assign xmod_en = mode_ctrl[BRA_XMOD_EN_BIT];
  assign apb_access = psel_i & penable_i;
  // transfer completes on the edge where the master sees pready high
  assign apb_done = apb_access & pready;
  assign addr_hit = (paddr_i == BRA_OFS_MODE_CTRL) || (paddr_i == BRA_OFS_BITREV_CTRL) ||
                    (paddr_i == BRA_OFS_TABLE_PAGE) || (paddr_i == BRA_OFS_STATUS);

  // apb slave: one wait state, answer registered so outputs come from flops
  always_comb begin
    next_mode_ctrl = mode_ctrl;
    next_bitrev_control = bitrev_control;
    next_table_page = table_page;
    next_pready = apb_access & ~pready;
    next_pslverr = apb_access & ~pready & ~addr_hit;
    next_prdata = 32'h0000_0000;
    if (apb_access && !pready) begin
      case (paddr_i)
        BRA_OFS_MODE_CTRL: next_prdata = {16'h0000, mode_ctrl};
        BRA_OFS_BITREV_CTRL: next_prdata = {16'h0000, bitrev_control};
        BRA_OFS_TABLE_PAGE: next_prdata = {24'h00_0000, table_page};
        BRA_OFS_STATUS: next_prdata = {bitrev_count, 8'h00, last_ea};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    // status register is read only; writes to it are dropped
    if (apb_done && pwrite_i) begin
      case (paddr_i)
        BRA_OFS_MODE_CTRL: next_mode_ctrl = pwdata_i[15:0];
        BRA_OFS_BITREV_CTRL: next_bitrev_control = pwdata_i[15:0];
        BRA_OFS_TABLE_PAGE: next_table_page = pwdata_i[7:0];
        default: next_mode_ctrl = mode_ctrl;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_ctrl <= BRA_MODE_CTRL_RST;
      bitrev_control <= BRA_BITREV_CTRL_RST;
      table_page <= BRA_TABLE_PAGE_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      mode_ctrl <= next_mode_ctrl;
      bitrev_control <= next_bitrev_control;
      table_page <= next_table_page;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // reverse all 15 bits of a pointer word index
  function automatic logic [14:0] bra_reverse(input logic [14:0] v);
    logic [14:0] r;
    r = 15'h0000;
    for (int i = 0; i < 15; i++) begin
      r[i] = v[14 - i];
    end
    return r;
  endfunction : bra_reverse

  // address calculation for the pipeline request
  logic is_inc;
  logic is_dec;
  logic is_pre;
  logic bitrev_active;
  logic [14:0] pivot_word;
  logic [14:0] rev_sum;
  logic [15:0] bitrev_next;
  logic [15:0] step;
  logic [15:0] modified;
  logic [15:0] ea;

  assign is_inc = (req_i.mode == BRA_AM_PRE_INC) || (req_i.mode == BRA_AM_POST_INC);
  assign is_dec = (req_i.mode == BRA_AM_PRE_DEC) || (req_i.mode == BRA_AM_POST_DEC);
  assign is_pre = (req_i.mode == BRA_AM_PRE_INC) || (req_i.mode == BRA_AM_PRE_DEC);
  // x unit write path only, word data, increment modes, armed pointer
  assign bitrev_active = (bitrev_pointer_select != BRA_PTR_NONE) && bitrev_enable &&
                         is_inc && req_i.write && !req_i.byte_access &&
                         !req_i.table_access && !req_i.remap_access &&
                         (req_i.wreg == bitrev_pointer_select);
  // pivot counts words, so it lines up with pointer bits 15 to 1
  assign pivot_word = 15'(bitrev_pivot);
  // carries run from msb down: add in reversed order then reverse back
  assign rev_sum = bra_reverse(15'(bra_reverse(req_i.wvalue[15:1]) +
                                   bra_reverse(pivot_word)));
  // increment offset of the mode is ignored and lsb is forced clear
  assign bitrev_next = {rev_sum, 1'b0};
  assign step = req_i.byte_access ? BRA_STEP_BYTE : BRA_STEP_WORD;

  always_comb begin
    modified = req_i.wvalue;
    if (bitrev_active) begin
      modified = bitrev_next;
    end else if (is_inc) begin
      modified = 16'(req_i.wvalue + step);
    end else if (is_dec) begin
      modified = 16'(req_i.wvalue - step);
    end
  end

  always_comb begin
    case (req_i.mode)
      BRA_AM_PRE_INC, BRA_AM_PRE_DEC: ea = modified;
      BRA_AM_REG_OFS, BRA_AM_LIT_OFS: ea = 16'(req_i.wvalue + req_i.offset);
      default: ea = req_i.wvalue;
    endcase
  end

  // answer to the pipeline, one cycle after the request
  always_comb begin
    next_rsp = '0;
    next_last_ea = last_ea;
    next_bitrev_count = bitrev_count;
    if (req_i.valid) begin
      next_rsp.valid = 1'b1;
      next_rsp.ea = (bitrev_active && is_pre) ? {ea[15:1], 1'b0} : ea;
      next_rsp.wb_en = is_inc || is_dec;
      next_rsp.wb_value = modified;
      next_rsp.bitrev_used = bitrev_active;
      // bitrev owns the pointer update, so modulo correction stands aside
      next_rsp.modulo_apply = xmod_en && (xmod_sel != BRA_PTR_NONE) &&
                              (req_i.wreg == xmod_sel) && !bitrev_active;
      if (req_i.table_access) begin
        // page above effective address; lsb kept clear, byte picked separately
        next_rsp.ps_addr = {table_page, ea[15:1], 1'b0};
        next_rsp.byte_select = ea[0];
        next_rsp.config_space = table_page[BRA_CFG_SPACE_BIT];
      end else if (req_i.remap_access) begin
        // remapped window is a read-only view of the low program word
        next_rsp.ps_addr = {table_page, ea[15:1], 1'b0};
        next_rsp.low_word_only = 1'b1;
        next_rsp.refused = req_i.write;
      end
      next_last_ea = next_rsp.ea;
      if (bitrev_active) begin
        next_bitrev_count = 8'(bitrev_count + 8'h01);
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp <= '0;
      last_ea <= 16'h0000;
      bitrev_count <= 8'h00;
    end else begin
      rsp <= next_rsp;
      last_ea <= next_last_ea;
      bitrev_count <= next_bitrev_count;
    end
  end

  // outputs straight from flops
  assign prdata_o = prdata;
  assign pready_o = pready;
  assign pslverr_o = pslverr;
  assign rsp_o = rsp;
endmodule : bra_agu

// ==== tb/bra_agu_asserts.sv ====
// checker: timing and field relations at the address generator ports
`timescale 1ns/100ps
module bra_agu_asserts #(
  parameter int PIVOT_W = 15
) (
  // clock, reset and apb handshake
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  // pipeline request and answer
  input wire bra_pkg::bra_req_t req_i,
  input wire bra_pkg::bra_rsp_t rsp_o
);
  import bra_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // answers trail requests by one cycle; later edges would stall the pipeline
  property p_lat;
    req_i.valid |=> rsp_o.valid; endproperty
  a_lat: assert property (p_lat) else $error("answer late");
  property p_tbl;
    req_i.valid && req_i.table_access && req_i.mode == BRA_AM_INDIRECT |=>
      rsp_o.ps_addr[15:0] == {$past(req_i.wvalue[15:1]), 1'h0}
      && rsp_o.byte_select == $past(req_i.wvalue[0]); endproperty
  a_tbl: assert property (p_tbl) else $error("table address");
  property p_cfg;
    req_i.valid && req_i.table_access |=> rsp_o.config_space == rsp_o.ps_addr[23];
  endproperty
  a_cfg: assert property (p_cfg) else $error("space select");
  property p_brev;
    req_i.valid && !(req_i.write && !req_i.byte_access && (req_i.mode == BRA_AM_PRE_INC
      || req_i.mode == BRA_AM_POST_INC)) |=> !rsp_o.bitrev_used; endproperty
  a_brev: assert property (p_brev) else $error("reverse misused");
  property p_lsb;
    rsp_o.bitrev_used |-> rsp_o.wb_value[0] == 1'h0; endproperty
  a_lsb: assert property (p_lsb) else $error("odd reversed address");
  property p_mod;
    rsp_o.bitrev_used |-> !rsp_o.modulo_apply; endproperty
  a_mod: assert property (p_mod) else $error("modulo beat reverse");
  property p_ro;
    req_i.valid && req_i.remap_access && req_i.write |=> rsp_o.refused; endproperty
  a_ro: assert property (p_ro) else $error("remap write taken");
  property p_rdy;
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing");
endmodule : bra_agu_asserts
bind bra_agu bra_agu_asserts #(.PIVOT_W(PIVOT_W)) bra_agu_asserts_inst (.clk_i, .reset_n_i,
  .psel_i, .penable_i, .pready_o, .req_i, .rsp_o);

// ==== tb/bra_pipe_model.sv ====
// partner: execution pipeline issuing one address request per call
`timescale 1ns/100ps
module bra_pipe_model (
  // core clock and answer
  input wire logic clk_i,
  input wire bra_pkg::bra_rsp_t rsp_i,
  // request
  output bra_pkg::bra_req_t req_o
);
  import bra_pkg::*;
  bra_rsp_t got;
  bra_req_t idle;
  initial req_o = '0;
  // idle fields show the inverse, so stale operands are never reused by luck
  task automatic send(input bra_req_t r);
    int n;
    req_o <= r;
    idle = ~r;
    idle.valid = 1'h0;
    @(posedge clk_i);
    req_o <= idle;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp_i.valid !== 1'h1 && n < 8);
    got = rsp_i;
  endtask : send
endmodule : bra_pipe_model

// ==== tb/testbench.sv ====
// testbench: registers, bit-reversed walk and program space addressing
`timescale 1ns/100ps
module testbench;
  import bra_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic er;
  bra_req_t req;
  bra_rsp_t rsp;
  bra_rsp_t got;
  int err_total = 0;
  int total_checks = 0;
  // 25 ns period
  always #12.5 clk = ~clk;
  bra_agu bra_agu_inst (.clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .req_i(req), .rsp_o(rsp));
  bra_pipe_model bra_pipe_model_inst (.clk_i(clk), .rsp_i(rsp), .req_o(req));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // apb master: request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'h1) begin
      err_total++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  // f holds write, byte, table and remap flags
  task automatic pipe(input bra_mode_t m, input logic [3:0] wr, input logic [15:0] w,
      input logic [3:0] f);
    bra_req_t r;
    r = '0;
    r.valid = 1'h1;
    r.mode = m;
    r.wreg = wr;
    r.wvalue = w;
    {r.write, r.byte_access, r.table_access, r.remap_access} = f;
    bra_pipe_model_inst.send(r);
    got = bra_pipe_model_inst.got;
    chk("valid", 32'h1, {31'h0, got.valid});
  endtask : pipe
  function automatic logic [31:0] seen();
    return {15'h0, got.bitrev_used, got.wb_value};
  endfunction : seen
  task automatic t_regs;
    apb(1'h0, BRA_OFS_MODE_CTRL, 32'h0);
    chk("mode", {16'h0, BRA_MODE_CTRL_RST}, rd);
    apb(1'h0, BRA_OFS_TABLE_PAGE, 32'h0);
    chk("page", {24'h0, BRA_TABLE_PAGE_RST}, rd);
    apb(1'h0, 8'h10, 32'h0);
    chk("err", 32'h1, {31'h0, er});
    apb(1'h1, BRA_OFS_BITREV_CTRL, 32'hFFFF_8008);
    apb(1'h0, BRA_OFS_BITREV_CTRL, 32'h0);
    chk("ctl", 32'h8008, rd);
    apb(1'h1, BRA_OFS_MODE_CTRL, 32'h8505);
  endtask : t_regs
  // 16-entry buffer at 0, pivot 8; pre and post modes alternate
  task automatic t_walk;
    logic [3:0] j;
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      j = 4'(i);
      k = 4'(i + 1);
      pipe(j[0] ? BRA_AM_PRE_INC : BRA_AM_POST_INC, 4'h5,
        {11'h0, j[0], j[1], j[2], j[3], 1'h0}, 4'h8);
      chk("wb", {16'h1, 11'h0, k[0], k[1], k[2], k[3], 1'h0}, seen());
      // pre-increment shows the updated pointer, post-increment the old one
      chk("ea", {27'h0, j[0] ? {k[0], k[1], k[2], k[3]} : {j[0], j[1], j[2], j[3]}, 1'h0},
        {16'h0, got.ea});
    end
    apb(1'h0, BRA_OFS_STATUS, 32'h0);
    chk("count", 32'h10, {24'h0, rd[31:24]});
  endtask : t_walk
  task automatic t_plain;
    pipe(BRA_AM_POST_INC, 4'h5, 16'h0040, 4'hC);
    chk("byte", 32'h41, seen());
    pipe(BRA_AM_POST_INC, 4'h5, 16'h0040, 4'h0);
    chk("read", 32'h42, seen());
    // without bit reversal the modulo pointer gets its correction flag
    chk("mod", 32'h1, {31'h0, got.modulo_apply});
    pipe(BRA_AM_PRE_DEC, 4'h5, 16'h0040, 4'h8);
    chk("dec", 32'h3E, seen());
    pipe(BRA_AM_POST_INC, 4'h6, 16'h0040, 4'h8);
    chk("wreg", 32'h42, seen());
    apb(1'h1, BRA_OFS_BITREV_CTRL, 32'h0008);
    pipe(BRA_AM_POST_INC, 4'h5, 16'h0040, 4'h8);
    chk("off", 32'h42, seen());
  endtask : t_plain
  task automatic t_table;
    apb(1'h1, BRA_OFS_TABLE_PAGE, 32'h85);
    pipe(BRA_AM_INDIRECT, 4'h5, 16'h1235, 4'h2);
    chk("ps", 32'h0385_1234, {6'h0, got.byte_select, got.config_space, got.ps_addr});
    apb(1'h1, BRA_OFS_TABLE_PAGE, 32'h12);
    pipe(BRA_AM_INDIRECT, 4'h5, 16'h4000, 4'hA);
    chk("psw", 32'h0012_4000, {6'h0, got.byte_select, got.config_space, got.ps_addr});
    pipe(BRA_AM_INDIRECT, 4'h5, 16'h0010, 4'h9);
    chk("rmw", 32'h1, {31'h0, got.refused});
    pipe(BRA_AM_INDIRECT, 4'h5, 16'h0010, 4'h1);
    chk("rmr", 32'h2, {30'h0, got.low_word_only, got.refused});
  endtask : t_table
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_walk();
    t_plain();
    t_table();
    final_report();
  end
  // watchdog far beyond the hundred or so cycles needed
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule : testbench
